// ===== rtl/ktg_pkg.sv
// Package: register map, reset values and timing constants of the key-click tone generator
package ktg_pkg;
   localparam logic [6:0] REG_LEFT_GAIN = 7'h47;
   localparam logic [6:0] REG_RIGHT_GAIN = 7'h48;
   localparam logic [6:0] REG_LEN_HIGH = 7'h49;
   localparam logic [6:0] REG_LEN_MID = 7'h4A;
   localparam logic [6:0] REG_LEN_LOW = 7'h4B;
   localparam logic [6:0] REG_SIN_HIGH = 7'h4C;
   localparam logic [6:0] REG_SIN_LOW = 7'h4D;
   localparam logic [6:0] REG_COS_HIGH = 7'h4E;
   localparam logic [6:0] REG_COS_LOW = 7'h4F;
   localparam logic [7:0] RST_GAIN = 8'h00;
   localparam logic [7:0] RST_LEN_HIGH = 8'h00;
   localparam logic [7:0] RST_LEN_MID = 8'h00;
   localparam logic [7:0] RST_LEN_LOW = 8'hEE;
   localparam logic [7:0] RST_SIN_HIGH = 8'h10;
   localparam logic [7:0] RST_SIN_LOW = 8'hD8;
   localparam logic [7:0] RST_COS_HIGH = 8'h7E;
   localparam logic [7:0] RST_COS_LOW = 8'hE3;
   localparam int ENABLE_BIT = 7;
   localparam int GAIN_MSB = 5;
   localparam int MASTER_LSB = 6;
   localparam logic [5:0] GAIN_MAX_ATTEN = 6'h3F;
   localparam int CLK_MHZ = 125;
   localparam int ROM_LOAD_US = 100;
   localparam int ROM_LOAD_CYCLES = ROM_LOAD_US * CLK_MHZ;
   localparam int BIQUAD_WORDS = 32;
   localparam logic [23:0] ALLPASS_UNITY = 24'h7FFFFF;
endpackage : ktg_pkg

// ===== rtl/ktg_skid_buf.sv
// Two-entry valid/ready buffer in the mixed sample path
`timescale 1ns/100ps
`default_nettype none
module ktg_skid_buf #(
   parameter int WIDTH = 16
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   logic [WIDTH-1:0] mem [2];
   logic [1:0] count;
   logic wr_ptr;
   logic rd_ptr;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign in_ready_o = (count != 2'h2);
   assign out_valid_o = (count != 2'h0);
   assign out_data_o = mem[rd_ptr];

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count <= 2'h0;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   a_no_overflow: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (count == 2'h2 && !pop) |=> count == 2'h2)
      else $error("buffer count changed while full and not drained");
endmodule : ktg_skid_buf
`default_nettype wire

// ===== rtl/ktg_tone_gen.sv
// Key-click tone generator: registers, sine oscillator, volume, mixer, coefficient boot load
// Function
// [R1] Generate a digital sine tone in the playback path and send it to DAC.
// [R2] Sine coefficient is 16 bits: register 76 upper byte, 77 lower byte.
// [R3] Cosine coefficient is 16 bits: register 78 upper byte, 79 lower byte.
// [R4] Burst length is 24 bits from registers 73, 74, 75; one step per sample.
// [R5] Any length up to 24-bit maximum; burst lasts exactly that many samples.
// [R6] Reset defaults: length 00 00 EE, sine 10 D8, cosine 7E E3.
// [R7] Each channel gain is 6 bits, +2 dB down to -61 dB, 1 dB steps; code spans about 0 dB to -63 dB and applies only the left gain.
// [R8] Left gain in bits 5..0 of register 71, right in 5..0 of 72.
// [R9] Master tone volume sits in bits 7..6 of register 72.
// [R10] Tone volumes reset to +2 dB, the loudest setting; code resets to code 0, about 0 dB.
// [R11] Tone is added after playback volume, so playback volume leaves it unchanged.
// [R12] Host picks tone frequency below a quarter of the sample rate.
// [R13] Host zeroes unused upper bits of coefficient registers.
// [R14] Host zeroes unused upper bits of length registers.
// [R15] Host mutes, stops divider, sets enable, restarts divider, unmutes to insert tone.
// [R16] System must not derive serial audio clocks from the stoppable DAC clocks.
// [R17] After hardware or software reset copy all-pass coefficients into filter RAM.
// [R18] Host leaves coefficient pages alone for 100 us after reset.
// [R19] Host loads all filter coefficients before powering the DAC.
// [R20] When length expires clear enable and stop adding tone samples.
`timescale 1ns/100ps
`default_nettype none
module ktg_tone_gen #(
   parameter int SAMPLE_W = 16,
   parameter int LOAD_CYCLES = ktg_pkg::ROM_LOAD_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic soft_reset_i,
   input wire logic reg_wr_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire logic sample_tick_i,
   input wire logic [SAMPLE_W-1:0] play_data_i,
   output logic [SAMPLE_W-1:0] dac_data_o,
   output logic dac_valid_o,
   input wire logic dac_ready_i,
   output logic tone_active_o,
   output logic coef_we_o,
   output logic [4:0] coef_addr_o,
   output logic [23:0] coef_data_o,
   output logic coef_busy_o
);
   import ktg_pkg::*;

   typedef enum logic [1:0] {KTG_IDLE, KTG_LOAD, KTG_DONE} ktg_load_e;

   logic [7:0] tone_left_gain_ctrl;
   logic [7:0] tone_right_gain_ctrl;
   logic [7:0] tone_length_high;
   logic [7:0] tone_length_mid;
   logic [7:0] tone_length_low;
   logic [7:0] tone_sine_high;
   logic [7:0] tone_sine_low;
   logic [7:0] tone_cosine_high;
   logic [7:0] tone_cosine_low;
   logic [23:0] remain;
   logic signed [17:0] osc_cur;
   logic signed [17:0] osc_prev;
   logic signed [SAMPLE_W-1:0] mixed;
   logic mix_valid;
   logic mix_ready;
   logic buf_valid;
   logic [SAMPLE_W-1:0] buf_data;
   logic burst_end;
   logic [7:0] next_rdata;
   ktg_load_e load_state;
   logic [16:0] load_cnt;
   logic [4:0] load_addr;

   // Gain code n attenuates by about n dB; approximate by 6 dB shifts plus fine step table
   function automatic logic signed [17:0] apply_gain(input logic signed [17:0] s,
                                                     input logic [5:0] code);
      logic [5:0] att;
      logic signed [35:0] prod;
      logic [15:0] frac;
      att = code;
      case (att % 6'd6)
         6'd0: frac = 16'hFEC9;
         6'd1: frac = 16'hE314;
         6'd2: frac = 16'hCA62;
         6'd3: frac = 16'hB460;
         6'd4: frac = 16'hA0C2;
         default: frac = 16'h8F3D;
      endcase
      prod = (s * $signed({2'b00, frac})) >>> 16;
      apply_gain = 18'(prod >>> (att / 6'd6));
   endfunction : apply_gain

   function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [SAMPLE_W+1:0] v);
      if (v > $signed((SAMPLE_W+2)'({1'b0, {(SAMPLE_W-1){1'b1}}}))) begin
         sat = {1'b0, {(SAMPLE_W-1){1'b1}}};
      end else if (v < -$signed((SAMPLE_W+2)'({1'b0, {(SAMPLE_W-1){1'b1}}}))) begin
         sat = {1'b1, {(SAMPLE_W-1){1'b0}}};
      end else begin
         sat = v[SAMPLE_W-1:0];
      end
   endfunction : sat

   ////////////////////////////////////////////////////////////////////////////
   // Register file
   assign burst_end = tone_active_o && sample_tick_i && mix_ready && (remain == 24'h000001);

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tone_left_gain_ctrl <= RST_GAIN; // R10
         tone_right_gain_ctrl <= RST_GAIN; // R10
         tone_length_high <= RST_LEN_HIGH; // R6
         tone_length_mid <= RST_LEN_MID;
         tone_length_low <= RST_LEN_LOW;
         tone_sine_high <= RST_SIN_HIGH;
         tone_sine_low <= RST_SIN_LOW;
         tone_cosine_high <= RST_COS_HIGH;
         tone_cosine_low <= RST_COS_LOW;
      end else if (soft_reset_i) begin
         tone_left_gain_ctrl <= RST_GAIN;
         tone_right_gain_ctrl <= RST_GAIN;
         tone_length_high <= RST_LEN_HIGH;
         tone_length_mid <= RST_LEN_MID;
         tone_length_low <= RST_LEN_LOW;
         tone_sine_high <= RST_SIN_HIGH;
         tone_sine_low <= RST_SIN_LOW;
         tone_cosine_high <= RST_COS_HIGH;
         tone_cosine_low <= RST_COS_LOW;
      end else begin
         if (reg_wr_i) begin
            case (reg_addr_i)
               REG_LEFT_GAIN: tone_left_gain_ctrl <= reg_wdata_i;
               REG_RIGHT_GAIN: tone_right_gain_ctrl <= reg_wdata_i;
               REG_LEN_HIGH: tone_length_high <= reg_wdata_i; // R4
               REG_LEN_MID: tone_length_mid <= reg_wdata_i;
               REG_LEN_LOW: tone_length_low <= reg_wdata_i;
               REG_SIN_HIGH: tone_sine_high <= reg_wdata_i; // R2
               REG_SIN_LOW: tone_sine_low <= reg_wdata_i;
               REG_COS_HIGH: tone_cosine_high <= reg_wdata_i; // R3
               REG_COS_LOW: tone_cosine_low <= reg_wdata_i;
               default: ;
            endcase
         end
         // A host write of the enable in the same cycle wins over the hardware clear
         if (burst_end && !(reg_wr_i && reg_addr_i == REG_LEFT_GAIN)) begin
            tone_left_gain_ctrl[ENABLE_BIT] <= 1'b0; // R20
         end
      end
   end

   always_comb begin
      case (reg_addr_i)
         REG_LEFT_GAIN: next_rdata = tone_left_gain_ctrl;
         REG_RIGHT_GAIN: next_rdata = tone_right_gain_ctrl;
         REG_LEN_HIGH: next_rdata = tone_length_high;
         REG_LEN_MID: next_rdata = tone_length_mid;
         REG_LEN_LOW: next_rdata = tone_length_low;
         REG_SIN_HIGH: next_rdata = tone_sine_high;
         REG_SIN_LOW: next_rdata = tone_sine_low;
         REG_COS_HIGH: next_rdata = tone_cosine_high;
         REG_COS_LOW: next_rdata = tone_cosine_low;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Burst counter and oscillator, one step per accepted sample
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tone_active_o <= 1'b0;
         remain <= 24'h000000;
         osc_cur <= 18'sh00000;
         osc_prev <= 18'sh00000;
      end else if (soft_reset_i) begin
         tone_active_o <= 1'b0;
         remain <= 24'h000000;
      end else if (!tone_active_o) begin
         // Start on enable; a zero length plays nothing
         if (tone_left_gain_ctrl[ENABLE_BIT] &&
             {tone_length_high, tone_length_mid, tone_length_low} != 24'h000000) begin
            tone_active_o <= 1'b1;
            remain <= {tone_length_high, tone_length_mid, tone_length_low}; // R5
            osc_cur <= 18'sh00000;
            osc_prev <= -$signed({2'b00, tone_sine_high, tone_sine_low});
         end
      end else if (sample_tick_i && mix_ready) begin
         // Recursive oscillator: y[n] = 2*cos*y[n-1] - y[n-2], coefficients in Q15
         osc_prev <= osc_cur;
         // Product is formed at full width; an 18-bit product would wrap whenever the sample is more than a few counts from zero
         osc_cur <= 18'((($signed({20'h00000, tone_cosine_high, tone_cosine_low}) *
                    36'(osc_cur)) >>> 14) - osc_prev); // R1
         remain <= remain - 24'h000001;
         if (remain == 24'h000001) begin
            tone_active_o <= 1'b0; // R20
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Volume and mixer; left and master gains combined for the mono path
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mixed <= '0;
         mix_valid <= 1'b0;
      end else if (sample_tick_i && mix_ready) begin
         // Playback arrives already scaled, so the tone level is independent of it
         if (tone_active_o) begin
            mixed <= sat((SAMPLE_W+2)'($signed(play_data_i)) +
               (SAMPLE_W+2)'(apply_gain(apply_gain(osc_cur,
                  tone_left_gain_ctrl[GAIN_MSB:0]), // R7 R8
                  6'(tone_right_gain_ctrl[7:MASTER_LSB] * 6'd6)) >>> (18 - SAMPLE_W))); // R9 R11
         end else begin
            mixed <= play_data_i;
         end
         mix_valid <= 1'b1;
      end else begin
         mix_valid <= 1'b0;
      end
   end

   ktg_skid_buf #(.WIDTH(SAMPLE_W)) u_buf (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(mix_valid),
      .in_ready_o(mix_ready),
      .in_data_i(mixed),
      .out_valid_o(buf_valid),
      .out_ready_i(!dac_valid_o || dac_ready_i),
      .out_data_o(buf_data)
   );

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dac_valid_o <= 1'b0;
         dac_data_o <= '0;
      end else if (!dac_valid_o || dac_ready_i) begin
         dac_valid_o <= buf_valid;
         dac_data_o <= buf_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Boot load of all-pass coefficients into filter RAM
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         load_state <= KTG_IDLE;
         load_cnt <= '0;
         load_addr <= '0;
         coef_we_o <= 1'b0;
         coef_addr_o <= '0;
         coef_data_o <= '0;
         coef_busy_o <= 1'b1;
      end else if (soft_reset_i) begin
         load_state <= KTG_IDLE;
         coef_we_o <= 1'b0;
         coef_busy_o <= 1'b1;
      end else begin
         case (load_state)
            KTG_IDLE: begin
               load_cnt <= '0;
               load_addr <= '0;
               coef_busy_o <= 1'b1;
               load_state <= KTG_LOAD;
            end
            KTG_LOAD: begin
               load_cnt <= load_cnt + 17'h00001;
               coef_we_o <= (load_cnt < 17'(BIQUAD_WORDS)); // R17
               coef_addr_o <= load_addr;
               // All-pass biquad: unity b0, other taps zero
               coef_data_o <= (load_addr % 5'd5 == 5'd0) ? ALLPASS_UNITY : 24'h000000;
               if (load_cnt < 17'(BIQUAD_WORDS)) begin
                  load_addr <= load_addr + 5'h01;
               end
               if (load_cnt >= 17'(LOAD_CYCLES - 1)) begin
                  coef_busy_o <= 1'b0; // R18
                  load_state <= KTG_DONE;
               end
            end
            KTG_DONE: begin
               coef_we_o <= 1'b0;
               coef_busy_o <= 1'b0;
            end
            default: load_state <= KTG_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_last_sample;
      tone_active_o && sample_tick_i && mix_ready && remain == 24'h000001;
   endsequence

   a_burst_stops: assert property (@(posedge core_clk_i) disable iff (!resetn_i || soft_reset_i)
      s_last_sample |=> !tone_active_o) // R20
      else $error("tone still active after last sample");

   a_count_step: assert property (@(posedge core_clk_i) disable iff (!resetn_i || soft_reset_i)
      (tone_active_o && sample_tick_i && mix_ready && remain > 24'h000001)
      |=> remain == $past(remain) - 24'h000001) // R5
      else $error("burst count did not step by one sample");

   a_start_len: assert property (@(posedge core_clk_i) disable iff (!resetn_i || soft_reset_i)
      $rose(tone_active_o) |-> remain == $past({tone_length_high, tone_length_mid,
         tone_length_low})) // R4
      else $error("burst did not load the programmed length");

   a_no_tone_idle: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (sample_tick_i && mix_ready && !tone_active_o) |=> mixed == $past(play_data_i)) // R11
      else $error("idle mixer output differs from playback data");

   a_enable_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i || soft_reset_i)
      (s_last_sample and !reg_wr_i) |=> !tone_left_gain_ctrl[ENABLE_BIT]) // R20
      else $error("enable not cleared at burst end");

   a_sine_write: assert property (@(posedge core_clk_i) disable iff (!resetn_i || soft_reset_i)
      (reg_wr_i && reg_addr_i == REG_SIN_LOW) |=> tone_sine_low == $past(reg_wdata_i)) // R2
      else $error("sine low byte not stored");

   a_cos_write: assert property (@(posedge core_clk_i) disable iff (!resetn_i || soft_reset_i)
      (reg_wr_i && reg_addr_i == REG_COS_HIGH) |=> tone_cosine_high == $past(reg_wdata_i)) // R3
      else $error("cosine high byte not stored");

   a_boot_done: assert property (@(posedge core_clk_i) disable iff (!resetn_i || soft_reset_i)
      $fell(coef_busy_o) |-> $past(load_cnt) == 17'(LOAD_CYCLES - 1)) // R17
      else $error("coefficient load ended at the wrong count");
endmodule : ktg_tone_gen
`default_nettype wire

// ===== tb/ktg_dac_sink.sv
// DAC-side sample sink: takes mixed words and stalls when told to
`timescale 1ns/100ps
`default_nettype none
module ktg_dac_sink (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic stall_i,
   input wire logic valid_i,
   input wire logic [15:0] data_i,
   output logic ready_o,
   output logic take_o,
   output logic [15:0] word_o
);
   // Ready moves only after a clock edge, so a stall lands a cycle late as in a real DAC
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ready_o <= 1'b0;
      end else begin
         ready_o <= !stall_i;
      end
   end
   assign take_o = valid_i && ready_o;
   assign word_o = data_i;
endmodule : ktg_dac_sink
`default_nettype wire

// ===== tb/ktg_tone_gen_tb_top.sv
// Self-checking bench for the key-click tone generator
`timescale 1ns/100ps
`default_nettype none
module ktg_tone_gen_tb_top;
   import ktg_pkg::*;
   localparam int LOAD = 40;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic soft_reset = 1'b0;
   logic reg_wr = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic sample_tick = 1'b0;
   logic [15:0] play_data = 16'h0000;
   logic [15:0] dac_data;
   logic dac_valid;
   logic dac_ready;
   logic tone_active;
   logic coef_we;
   logic coef_busy;
   logic [4:0] coef_addr;
   logic [23:0] coef_data;
   logic stall = 1'b0;
   logic take;
   logic [15:0] word;
   logic [15:0] got [$];
   int fails = 0;
   int compares = 0;
   int coef_cnt = 0;
   int coef_bad = 0;
   logic [31:0] coef_seen = 32'h0;
   logic [7:0] rst_tab [9] = '{RST_GAIN, RST_GAIN, RST_LEN_HIGH, RST_LEN_MID, RST_LEN_LOW,
                               RST_SIN_HIGH, RST_SIN_LOW, RST_COS_HIGH, RST_COS_LOW};
   logic [7:0] pat_tab [9] = '{8'h3F, 8'hC5, 8'h12, 8'h34, 8'h56, 8'h7F, 8'hA5, 8'h80, 8'h01};
   logic [15:0] play_tab [4] = '{16'h8000, 16'h7FFF, 16'h0001, 16'hFFFF};

   ktg_tone_gen #(.SAMPLE_W(16), .LOAD_CYCLES(LOAD)) i_dut (
      .core_clk_i(core_clk), .resetn_i(resetn), .soft_reset_i(soft_reset),
      .reg_wr_i(reg_wr), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_rdata_o(reg_rdata), .sample_tick_i(sample_tick), .play_data_i(play_data),
      .dac_data_o(dac_data), .dac_valid_o(dac_valid), .dac_ready_i(dac_ready),
      .tone_active_o(tone_active), .coef_we_o(coef_we), .coef_addr_o(coef_addr),
      .coef_data_o(coef_data), .coef_busy_o(coef_busy));

   ktg_dac_sink i_sink (
      .core_clk_i(core_clk), .resetn_i(resetn), .stall_i(stall), .valid_i(dac_valid),
      .data_i(dac_data), .ready_o(dac_ready), .take_o(take), .word_o(word));

   always #4 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      if (take) begin
         got.push_back(word);
      end
      if (coef_we) begin
         coef_cnt++;
         coef_seen[coef_addr] = 1'b1;
         // All-pass section: first tap of each five-word biquad is unity, the rest zero
         if (coef_data !== ((coef_addr % 5'd5 == 5'd0) ? ALLPASS_UNITY : 24'h000000)) begin
            coef_bad++;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] s);
      compares++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask : chk8

   task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] s);
      compares++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask : chk16

   task automatic chk1(input string what, input logic e, input logic s);
      compares++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %b seen %b", what, e, s);
      end
   endtask : chk1

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rchk(input string what, input logic [6:0] a, input logic [7:0] e);
      @(negedge core_clk);
      reg_addr = a;
      @(negedge core_clk);
      chk8(what, e, reg_rdata);
   endtask : rchk

   // Ticks stay four cycles apart so the mixer never sees them back to back
   task automatic tick(input logic [15:0] v);
      @(negedge core_clk);
      sample_tick = 1'b1;
      play_data = v;
      @(negedge core_clk);
      sample_tick = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask : tick

   task automatic done(input string name);
      $display("test %s finished, fails so far %0d", name, fails);
   endtask : done

   task automatic check_defaults();
      for (int i = 0; i < 9; i++) begin
         rchk("reset value", 7'(REG_LEFT_GAIN + i), rst_tab[i]);
      end
   endtask : check_defaults

   // Default coefficients keep the tone well under a quarter of the sample rate
   task automatic burst(input logic [23:0] n);
      logic hit;
      hit = 1'b0;
      wr(REG_SIN_HIGH, RST_SIN_HIGH);
      wr(REG_LEN_HIGH, n[23:16]);
      wr(REG_LEN_MID, n[15:8]);
      wr(REG_LEN_LOW, n[7:0]);
      got.delete();
      wr(REG_LEFT_GAIN, 8'h80);
      repeat (2) @(negedge core_clk);
      chk1("tone active at start", 1'b1, tone_active);
      for (int i = 1; i <= int'(n); i++) begin
         tick(16'h0000);
         chk1("tone active", 1'(i < int'(n)), tone_active);
      end
      repeat (6) @(negedge core_clk);
      foreach (got[k]) begin
         if (got[k] !== 16'h0000) begin
            hit = 1'b1;
         end
      end
      chk1("tone audible", 1'b1, hit);
      chk16("burst words", n[15:0], 16'(got.size()));
      rchk("enable cleared", REG_LEFT_GAIN, 8'h00);
      got.delete();
      tick(16'h1234);
      repeat (4) @(negedge core_clk);
      chk16("after burst", 16'h1234, got[0]);
   endtask : burst

   task automatic wrap_up();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(negedge core_clk);
      resetn = 1'b1;
      chk1("busy after reset", 1'b1, coef_busy);
      check_defaults();
      done("reset values");
      for (int i = 0; i < 9; i++) begin
         wr(7'(REG_LEFT_GAIN + i), pat_tab[i]);
      end
      for (int i = 0; i < 9; i++) begin
         rchk("readback", 7'(REG_LEFT_GAIN + i), pat_tab[i]);
      end
      wr(7'h50, 8'hAA);
      rchk("unmapped", 7'h50, 8'h00);
      rchk("unmapped", 7'h46, 8'h00);
      done("register access");
      @(negedge core_clk);
      coef_cnt = 0;
      coef_bad = 0;
      coef_seen = 32'h0;
      soft_reset = 1'b1;
      @(negedge core_clk);
      soft_reset = 1'b0;
      chk1("busy after soft reset", 1'b1, coef_busy);
      for (int i = 0; i < LOAD + 100 && coef_busy === 1'b1; i++) begin
         @(negedge core_clk);
      end
      chk1("busy done", 1'b0, coef_busy);
      chk16("coef writes", 16'h0020, 16'(coef_cnt));
      chk1("coef addresses", 1'b1, &coef_seen);
      chk16("coef data errors", 16'h0000, 16'(coef_bad));
      check_defaults();
      done("soft reset");
      chk1("load done before play", 1'b0, coef_busy);
      got.delete();
      foreach (play_tab[k]) tick(play_tab[k]);
      repeat (4) @(negedge core_clk);
      foreach (play_tab[k]) chk16("passthrough", play_tab[k], got[k]);
      got.delete();
      stall = 1'b1;
      foreach (play_tab[k]) tick(play_tab[k]);
      stall = 1'b0;
      repeat (8) @(negedge core_clk);
      // Output register plus two buffer entries hold three words; the fourth tick is refused
      chk16("stall kept words", 16'h0003, 16'(got.size()));
      foreach (got[k]) chk16("stalled word", play_tab[k], got[k]);
      done("passthrough and stall");
      burst(24'h000003);
      done("short burst");
      burst(24'h000102);
      done("mid byte burst");
      wrap_up();
   end

   initial begin
      repeat (40000) @(posedge core_clk);
      fails++;
      $display("[ERR] watchdog expected finish seen timeout");
      wrap_up();
   end
endmodule : ktg_tone_gen_tb_top
`default_nettype wire
